// >>> src/utvf_pkg.sv
// constants, command carrier and state codes for the under-temp / input-overvoltage fault block
package utvf_pkg;

    // command codes of the three threshold / action registers
    localparam logic [7:0] UTVF_CMD_UT_LIMIT = 8'h53;
    localparam logic [7:0] UTVF_CMD_UT_ACTION = 8'h54;
    localparam logic [7:0] UTVF_CMD_VIN_OV_LIMIT = 8'h55;

    // reset values
    localparam logic [15:0] UTVF_UT_LIMIT_RST = 16'he530;
    localparam logic [7:0] UTVF_UT_ACTION_RST = 8'h80;
    localparam logic [15:0] UTVF_VIN_OV_LIMIT_RST = 16'hda00;

    // two-byte word: signed exponent and signed mantissa
    localparam int UTVF_EXP_HI = 15;
    localparam int UTVF_EXP_LO = 11;
    localparam int UTVF_MANT_HI = 10;
    localparam int UTVF_FIX_W = 40;
    localparam int UTVF_FIX_FRAC = 8;

    // action byte fields
    localparam int UTVF_RESP_HI = 7;
    localparam int UTVF_RESP_LO = 6;
    localparam logic [1:0] UTVF_RESP_RETRY = 2'b10;
    localparam int UTVF_RETRY_HI = 5;
    localparam int UTVF_RETRY_LO = 3;
    localparam int UTVF_DELAY_HI = 2;
    localparam int UTVF_DELAY_LO = 0;

    // accepted ranges, in fixed point with UTVF_FIX_FRAC fraction bits
    localparam logic signed [39:0] UTVF_UT_MIN = -(40'sd55 <<< UTVF_FIX_FRAC);
    localparam logic signed [39:0] UTVF_UT_MAX = 40'sd25 <<< UTVF_FIX_FRAC;
    localparam logic signed [39:0] UTVF_VIN_MIN = 40'sd0;
    localparam logic signed [39:0] UTVF_VIN_MAX = 40'sd18 <<< UTVF_FIX_FRAC;

    // retry timing
    localparam int UTVF_CLK_HZ = 20_000_000;
    localparam int UTVF_RETRY_STEP_MS = 35;
    localparam int UTVF_RETRY_STEP_CYC = UTVF_CLK_HZ / 1000 * UTVF_RETRY_STEP_MS;
    localparam int UTVF_CNT_W = 24;

    // fault channels
    localparam int UTVF_CH_UT = 0;
    localparam int UTVF_CH_VIN = 1;
    localparam int UTVF_NUM_CH = 2;

    typedef struct packed {
        logic valid;
        logic write;
        logic [7:0] code;
        logic [15:0] data;
    } utvf_cmd_t;

    typedef enum logic [3:0] {
        UTVF_ST_RUN = 4'b0001,
        UTVF_ST_DELAY = 4'b0010,
        UTVF_ST_GATE = 4'b0100,
        UTVF_ST_LATCH = 4'b1000
    } utvf_state_t;

    // mantissa times two to the exponent, as signed fixed point
    function automatic logic signed [39:0] utvf_lin_to_fix(input logic [15:0] w);
        logic signed [4:0] n;
        logic signed [39:0] y;
        n = signed'(w[UTVF_EXP_HI:UTVF_EXP_LO]);
        y = signed'({{29{w[UTVF_MANT_HI]}}, w[UTVF_MANT_HI:0]});
        y = y <<< UTVF_FIX_FRAC;
        if (n >= 0) begin
            return y <<< 5'(n);
        end
        return y >>> 5'(-n);
    endfunction

endpackage

// >>> src/utvf_fault_cfg.sv
// under-temperature and input-overvoltage fault thresholds, action register and retry sequencing
// Behaviour
// - hold a programmable under-temperature fault threshold in degrees Celsius
// - thresholds are exponent/mantissa words valued mantissa times two to exponent
// - under-temperature threshold accepts -55 to +25 C; other writes refused
// - input overvoltage threshold accepts 0 to 18 V; other writes refused
// - under-temperature retry waits until temperature rises above its warning
// - overvoltage retry waits until input voltage drops below its warning
// - action bits 7:6 = 10 disable then retry per 5:3; other codes unused
// - taken under-temperature response pulls alert low and sets fault bit
// - fault bits stay set until a clear-faults command
// - retry field 000 keeps output off until device restart
// - retry 001-111 keeps retrying until off command, bias loss, latched fault on the other channel
// - retry interval is (delay field plus one) times 35 ms
// - the same delay runs from fault detection to first restart
// - action register resets to 80h, disable without retry
// - overvoltage restart begins only once voltage is under its warning
`timescale 1ns/100ps
module utvf_fault_cfg
    import utvf_pkg::*;
#(
    parameter int RETRY_STEP_CYCLES = UTVF_RETRY_STEP_CYC
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // command port
    input wire utvf_cmd_t cmd,
    input wire logic clear_faults,
    output logic [15:0] rd_data_q,
    output logic rd_valid_q,
    output logic wr_refused_q,
    // telemetry and neighbouring settings
    input wire logic [15:0] meas_temp,
    input wire logic [15:0] meas_vin,
    input wire logic [15:0] ut_warn_limit,
    input wire logic [15:0] vin_ov_warn_limit,
    input wire logic [7:0] vin_ov_action,
    input wire logic enable_cmd,
    // output control and status
    output logic output_enable_q,
    output logic [1:0] fault_status_q,
    output logic host_alert_line_o,
    output logic host_alert_line_oe_n
);

    localparam logic [UTVF_CNT_W-1:0] STEP_LAST = UTVF_CNT_W'(RETRY_STEP_CYCLES - 1);

    // register file
    logic [15:0] ut_limit_q, ut_limit_d;
    logic [7:0] ut_action_q, ut_action_d;
    logic [15:0] vin_limit_q, vin_limit_d;
    logic [15:0] rd_data_d;
    logic rd_valid_d, wr_refused_d;
    logic signed [39:0] wr_fix;
    logic wr_en;

    always_comb begin
        ut_limit_d = ut_limit_q;
        ut_action_d = ut_action_q;
        vin_limit_d = vin_limit_q;
        rd_data_d = rd_data_q;
        rd_valid_d = 1'b0;
        wr_refused_d = 1'b0;
        wr_fix = utvf_lin_to_fix(cmd.data);
        wr_en = cmd.valid && cmd.write;
        if (wr_en) begin
            case (cmd.code)
                UTVF_CMD_UT_LIMIT: begin
                    if (wr_fix >= UTVF_UT_MIN && wr_fix <= UTVF_UT_MAX) begin
                        ut_limit_d = cmd.data;
                    end else begin
                        wr_refused_d = 1'b1;
                    end
                end
                UTVF_CMD_UT_ACTION: ut_action_d = cmd.data[7:0];
                UTVF_CMD_VIN_OV_LIMIT: begin
                    if (wr_fix >= UTVF_VIN_MIN && wr_fix <= UTVF_VIN_MAX) begin
                        vin_limit_d = cmd.data;
                    end else begin
                        wr_refused_d = 1'b1;
                    end
                end
                default: wr_refused_d = 1'b1;
            endcase
        end else if (cmd.valid) begin
            rd_valid_d = 1'b1;
            case (cmd.code)
                UTVF_CMD_UT_LIMIT: rd_data_d = ut_limit_q;
                UTVF_CMD_UT_ACTION: rd_data_d = {8'h00, ut_action_q};
                UTVF_CMD_VIN_OV_LIMIT: rd_data_d = vin_limit_q;
                default: rd_data_d = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            ut_limit_q <= UTVF_UT_LIMIT_RST;
            ut_action_q <= UTVF_UT_ACTION_RST;
            vin_limit_q <= UTVF_VIN_OV_LIMIT_RST;
            rd_data_q <= 16'h0000;
            rd_valid_q <= 1'b0;
            wr_refused_q <= 1'b0;
        end else begin
            ut_limit_q <= ut_limit_d;
            ut_action_q <= ut_action_d;
            vin_limit_q <= vin_limit_d;
            rd_data_q <= rd_data_d;
            rd_valid_q <= rd_valid_d;
            wr_refused_q <= wr_refused_d;
        end
    end

    // detection and recovery per channel
    logic [UTVF_NUM_CH-1:0] fault_det, recovered, latched, taken, running;
    logic [7:0] action [UTVF_NUM_CH];

    assign fault_det[UTVF_CH_UT] = utvf_lin_to_fix(meas_temp) < utvf_lin_to_fix(ut_limit_q);
    assign fault_det[UTVF_CH_VIN] = utvf_lin_to_fix(meas_vin) > utvf_lin_to_fix(vin_limit_q);
    // restart gating relies on the host keeping warnings on the safe side
    assign recovered[UTVF_CH_UT] = utvf_lin_to_fix(meas_temp) > utvf_lin_to_fix(ut_warn_limit);
    assign recovered[UTVF_CH_VIN] = utvf_lin_to_fix(meas_vin) < utvf_lin_to_fix(vin_ov_warn_limit);
    assign action[UTVF_CH_UT] = ut_action_q;
    assign action[UTVF_CH_VIN] = vin_ov_action;

    // one retry sequencer per fault channel
    for (genvar i = 0; i < UTVF_NUM_CH; i++) begin : g_seq
        utvf_state_t st_q, st_d;
        logic [UTVF_CNT_W-1:0] cyc_q, cyc_d;
        logic [2:0] step_q, step_d;
        logic resp_on, other_latched;

        assign resp_on = action[i][UTVF_RESP_HI:UTVF_RESP_LO] == UTVF_RESP_RETRY;
        assign other_latched = |(latched & ~(UTVF_NUM_CH'(1) << i));
        assign latched[i] = st_q == UTVF_ST_LATCH;
        assign running[i] = st_q == UTVF_ST_RUN;
        assign taken[i] = running[i] && enable_cmd && fault_det[i] && resp_on;

        always_comb begin
            st_d = st_q;
            cyc_d = cyc_q;
            step_d = step_q;
            case (st_q)
                UTVF_ST_RUN: begin
                    if (taken[i]) begin
                        cyc_d = '0;
                        step_d = 3'd0;
                        if (action[i][UTVF_RETRY_HI:UTVF_RETRY_LO] == 3'd0) begin
                            st_d = UTVF_ST_LATCH;
                        end else begin
                            st_d = UTVF_ST_DELAY;
                        end
                    end
                end
                UTVF_ST_DELAY: begin
                    if (other_latched) begin
                        st_d = UTVF_ST_LATCH;
                    end else if (!enable_cmd) begin
                        st_d = UTVF_ST_RUN;
                    end else if (cyc_q == STEP_LAST) begin
                        cyc_d = '0;
                        step_d = step_q + 3'd1;
                        if (step_q == action[i][UTVF_DELAY_HI:UTVF_DELAY_LO]) begin
                            st_d = UTVF_ST_GATE;
                        end
                    end else begin
                        cyc_d = cyc_q + UTVF_CNT_W'(1);
                    end
                end
                UTVF_ST_GATE: begin
                    if (other_latched) begin
                        st_d = UTVF_ST_LATCH;
                    end else if (!enable_cmd || recovered[i]) begin
                        st_d = UTVF_ST_RUN;
                    end
                end
                UTVF_ST_LATCH: st_d = UTVF_ST_LATCH;
                default: st_d = UTVF_ST_LATCH;
            endcase
        end

        always_ff @(posedge clk_sys or negedge rstn) begin
            if (!rstn) begin
                st_q <= UTVF_ST_RUN;
                cyc_q <= '0;
                step_q <= 3'd0;
            end else begin
                st_q <= st_d;
                cyc_q <= cyc_d;
                step_q <= step_d;
            end
        end
    end

    // status, alert and output enable
    logic [1:0] status_d;
    logic out_en_d;

    always_comb begin
        // a fault taken in the clearing cycle still latches
        status_d = clear_faults ? 2'b00 : fault_status_q;
        status_d = status_d | taken;
        out_en_d = enable_cmd && (&running) && !(|taken);
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            fault_status_q <= 2'b00;
            output_enable_q <= 1'b0;
        end else begin
            fault_status_q <= status_d;
            output_enable_q <= out_en_d;
        end
    end

    // open-drain alert: pulled low while any fault bit is held
    assign host_alert_line_o = 1'b0;
    assign host_alert_line_oe_n = ~(|fault_status_q);

endmodule

// >>> bench/utvf_fault_cfg_chk.sv
// port assertions for the fault block
`timescale 1ns/100ps
module utvf_fault_cfg_chk
    import utvf_pkg::*;
#(
    parameter int RETRY_STEP_CYCLES = 8
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // command side
    input wire utvf_cmd_t cmd,
    input wire logic clear_faults,
    input wire logic rd_valid_q,
    input wire logic wr_refused_q,
    // output side
    input wire logic enable_cmd,
    input wire logic output_enable_q,
    input wire logic [1:0] fault_status_q,
    input wire logic host_alert_line_o,
    input wire logic host_alert_line_oe_n
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    // only unscaled words are judged here, scaled ones are left to the bench
    logic wr_n0, ut_bad, vin_bad;
    assign wr_n0 = cmd.valid && cmd.write && (cmd.data[15:11] == 5'h0);
    assign ut_bad = ($signed(cmd.data[10:0]) < -11'sd55) || ($signed(cmd.data[10:0]) > 11'sd25);
    assign vin_bad = ($signed(cmd.data[10:0]) < 11'sd0) || ($signed(cmd.data[10:0]) > 11'sd18);
    a_ut_range: assert property (wr_n0 && cmd.code == UTVF_CMD_UT_LIMIT |=> wr_refused_q == $past(ut_bad))
        else $error("under-temp limit refusal wrong");
    a_vin_range: assert property (wr_n0 && cmd.code == UTVF_CMD_VIN_OV_LIMIT |=> wr_refused_q == $past(vin_bad))
        else $error("overvoltage limit refusal wrong");
    a_refuse_cause: assert property (wr_refused_q |-> $past(cmd.valid && cmd.write))
        else $error("refusal without a write");
    a_read_answer: assert property (cmd.valid && !cmd.write |=> rd_valid_q)
        else $error("read not answered");
    a_alert_follows: assert property (host_alert_line_oe_n == ~|fault_status_q)
        else $error("alert not tied to fault bits");
    a_alert_data_low: assert property (!host_alert_line_o)
        else $error("alert data not low");
    a_sticky_status: assert property (|($past(fault_status_q) & ~fault_status_q) |-> $past(clear_faults))
        else $error("fault bit dropped without clear");
    a_off_on_fault: assert property ($rose(fault_status_q[0]) || $rose(fault_status_q[1]) |-> !output_enable_q)
        else $error("output on while fault taken");
    a_retry_wait: assert property ($fell(output_enable_q) && enable_cmd && $past(enable_cmd) |-> !output_enable_q [*8])
        else $error("restart before retry delay");
    a_enable_cause: assert property (output_enable_q |-> $past(enable_cmd))
        else $error("output on while commanded off");
endmodule

// >>> bench/utvf_host_model.sv
// host side model issuing command-layer transfers
`timescale 1ns/100ps
module utvf_host_model
    import utvf_pkg::*;
(
    // clock
    input wire logic clk_sys,
    // command port
    output utvf_cmd_t cmd,
    input wire logic [15:0] rd_data_q,
    input wire logic wr_refused_q
);
    initial cmd = '0;
    // idle fields are inverted so a stale value is never mistaken for a request
    task automatic xfer(input logic wr, input logic [7:0] c, input logic [15:0] d,
                        output logic [15:0] rdat, output logic refd);
        @(negedge clk_sys);
        cmd = '{valid: 1'b1, write: wr, code: c, data: d};
        @(negedge clk_sys);
        cmd = '{valid: 1'b0, write: ~wr, code: ~c, data: ~d};
        rdat = rd_data_q;
        refd = wr_refused_q;
    endtask
endmodule

// >>> bench/testbench.sv
// self-checking bench for the fault block
`timescale 1ns/100ps
module testbench;
    import utvf_pkg::*;
    logic clk_sys = 1'b0;
    logic rstn = 1'b0;
    utvf_cmd_t cmd;
    logic clear_faults = 1'b0;
    logic [15:0] rd_data_q, rdat;
    logic rd_valid_q, wr_refused_q, refd, output_enable_q, host_alert_line_o, host_alert_line_oe_n;
    logic [1:0] fault_status_q;
    // starts above every accepted limit so the limit writes below never trip a fault
    logic [15:0] meas_temp = 16'h001e;
    logic [15:0] meas_vin = 16'h000c;
    logic [15:0] ut_warn_limit = 16'h07e2;
    logic [15:0] vin_ov_warn_limit = 16'h000f;
    logic [7:0] vin_ov_action = 8'h88;
    logic enable_cmd = 1'b1;
    logic [7:0] unused[3] = '{8'h08, 8'h48, 8'hc8};
    int error_cnt = 0;
    int samples_checked = 0;
    always #25 clk_sys = ~clk_sys;
    utvf_fault_cfg #(.RETRY_STEP_CYCLES(8)) dut (.clk_sys, .rstn, .cmd, .clear_faults, .rd_data_q, .rd_valid_q,
        .wr_refused_q, .meas_temp, .meas_vin, .ut_warn_limit, .vin_ov_warn_limit, .vin_ov_action, .enable_cmd,
        .output_enable_q, .fault_status_q, .host_alert_line_o, .host_alert_line_oe_n);
    utvf_host_model host (.clk_sys, .cmd, .rd_data_q, .wr_refused_q);
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] c, input logic [15:0] d, input logic bad);
        host.xfer(1'b1, c, d, rdat, refd);
        chk("refused", {15'h0, refd}, {15'h0, bad});
    endtask
    task automatic rd(input logic [7:0] c, input logic [15:0] exp);
        host.xfer(1'b0, c, 16'h0000, rdat, refd);
        chk("read", rdat, exp);
        chk("valid", {15'h0, rd_valid_q}, 16'h0001);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_sys);
    endtask
    task automatic stat(input logic oe, input logic [1:0] st);
        chk("output", {15'h0, output_enable_q}, {15'h0, oe});
        chk("status", {14'h0, fault_status_q}, {14'h0, st});
        chk("alert", {15'h0, host_alert_line_oe_n}, {15'h0, ~|st});
    endtask
    task automatic clr();
        clear_faults = 1'b1;
        cyc(1);
        clear_faults = 1'b0;
        cyc(1);
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        #(4000 * 50);
        error_cnt++;
        give_verdict();
    end
    initial begin
        cyc(10);
        rstn = 1'b1;
        cyc(2);
        rd(UTVF_CMD_UT_LIMIT, UTVF_UT_LIMIT_RST);
        rd(UTVF_CMD_UT_ACTION, {8'h00, UTVF_UT_ACTION_RST});
        rd(UTVF_CMD_VIN_OV_LIMIT, UTVF_VIN_OV_LIMIT_RST);
        rd(8'h60, 16'h0000);
        wr(8'h60, 16'h0000, 1'b1);
        wr(UTVF_CMD_UT_LIMIT, 16'h07c4, 1'b1);
        wr(UTVF_CMD_UT_LIMIT, 16'h001e, 1'b1);
        wr(UTVF_CMD_UT_LIMIT, 16'h0fe4, 1'b1);
        wr(UTVF_CMD_UT_LIMIT, 16'h0fe5, 1'b0);
        rd(UTVF_CMD_UT_LIMIT, 16'h0fe5);
        wr(UTVF_CMD_UT_LIMIT, 16'h07c9, 1'b0);
        wr(UTVF_CMD_UT_LIMIT, 16'h0019, 1'b0);
        wr(UTVF_CMD_UT_LIMIT, UTVF_UT_LIMIT_RST, 1'b0);
        wr(UTVF_CMD_VIN_OV_LIMIT, 16'h0014, 1'b1);
        wr(UTVF_CMD_VIN_OV_LIMIT, 16'h07ff, 1'b1);
        wr(UTVF_CMD_VIN_OV_LIMIT, 16'h0012, 1'b0);
        rd(UTVF_CMD_VIN_OV_LIMIT, 16'h0012);
        meas_temp = 16'h07ce;
        cyc(2);
        stat(1'b0, 2'b01);
        chk("alert", {15'h0, host_alert_line_oe_n}, 16'h0000);
        meas_temp = 16'h0014;
        cyc(40);
        stat(1'b0, 2'b01);
        clr();
        stat(1'b0, 2'b00);
        rstn = 1'b0;
        cyc(2);
        rstn = 1'b1;
        cyc(2);
        stat(1'b1, 2'b00);
        wr(UTVF_CMD_UT_ACTION, 16'h008a, 1'b0);
        rd(UTVF_CMD_UT_ACTION, 16'h008a);
        meas_temp = 16'h07ce;
        cyc(1);
        meas_temp = 16'h0014;
        cyc(24);
        stat(1'b0, 2'b01);
        cyc(3);
        stat(1'b1, 2'b01);
        meas_temp = 16'h07ce;
        cyc(2);
        meas_temp = 16'h07d8;
        cyc(40);
        stat(1'b0, 2'b01);
        meas_temp = 16'h0014;
        cyc(6);
        stat(1'b1, 2'b01);
        clr();
        foreach (unused[i]) begin
            wr(UTVF_CMD_UT_ACTION, {8'h00, unused[i]}, 1'b0);
            meas_temp = 16'h07ce;
            cyc(3);
            stat(1'b1, 2'b00);
            meas_temp = 16'h0014;
        end
        meas_vin = 16'h0014;
        cyc(2);
        stat(1'b0, 2'b10);
        meas_vin = 16'h0010;
        cyc(20);
        stat(1'b0, 2'b10);
        meas_vin = 16'h000c;
        cyc(6);
        stat(1'b1, 2'b10);
        // long delay, so only an early exit on the off command can bring the output back in time
        wr(UTVF_CMD_UT_ACTION, 16'h008f, 1'b0);
        // clear and a new fault in one cycle: the new fault keeps its bit
        clear_faults = 1'b1;
        meas_temp = 16'h07ce;
        cyc(1);
        clear_faults = 1'b0;
        meas_temp = 16'h0014;
        enable_cmd = 1'b0;
        cyc(10);
        stat(1'b0, 2'b01);
        enable_cmd = 1'b1;
        cyc(2);
        stat(1'b1, 2'b01);
        give_verdict();
    end
endmodule
bind utvf_fault_cfg utvf_fault_cfg_chk #(.RETRY_STEP_CYCLES(RETRY_STEP_CYCLES)) chk (.clk_sys, .rstn, .cmd,
    .clear_faults, .rd_valid_q, .wr_refused_q, .enable_cmd, .output_enable_q, .fault_status_q,
    .host_alert_line_o, .host_alert_line_oe_n);
